// *** rtl/gauge_regs_pkg.sv ***
// Constants, layouts and reset values for the gauge mode/control registers.
// Assumes a byte-wide register port from the serial front end on mclk.
package gauge_regs_pkg;

	// Register addresses on the byte port
	localparam logic [6:0] MODE_ADDR    = 7'h00;
	localparam logic [6:0] CTRL_ADDR    = 7'h01;
	localparam logic [6:0] OCV_TAB_BASE = 7'h30;
	localparam logic [6:0] SOC_TAB_BASE = 7'h50;
	localparam logic [6:0] TAB_END      = 7'h60;
	localparam int         TAB_POINTS   = 16;

	// Mode register bit positions
	localparam int MODE_VOLT_ONLY = 0;
	localparam int MODE_PULLUP    = 1;
	localparam int MODE_CD_FORCE  = 2;
	localparam int MODE_ALARM_EN  = 3;
	localparam int MODE_RUN       = 4;
	localparam int MODE_FORCE_COUNTING_STATE  = 5;
	localparam int MODE_FORCE_VOLTAGE_STATE  = 6;

	// Control/status register bit positions
	localparam int CTRL_ALARM_PIN = 0;
	localparam int CTRL_CNT_CLEAR = 1;
	localparam int CTRL_SOC_VOLT  = 2;
	localparam int CTRL_REMOVED   = 3;
	localparam int CTRL_POR       = 4;
	localparam int CTRL_LOW_SOC   = 5;
	localparam int CTRL_LOW_VOLT  = 6;
	localparam int CTRL_UVLO      = 7;

	// Values after reset
	localparam logic [4:0] MODE_RESET = 5'h0B;
	localparam logic       ALARM_DRIVE_RESET = 1'b1;
	localparam logic       POR_DET_RESET     = 1'b1;

	// Default lookup table, entry 0 in the low slice
	localparam logic [TAB_POINTS-1:0][15:0] OCV_DEFAULT = {
		16'h1DA9, 16'h1CF3, 16'h1C58, 16'h1BE8, 16'h1BB1, 16'h1B70, 16'h1B01, 16'h1AD5,
		16'h1AB6, 16'h1A9D, 16'h1A6D, 16'h1A3E, 16'h19FB, 16'h19B2, 16'h1926, 16'h1770};
	localparam logic [TAB_POINTS-1:0][7:0] SOC_DEFAULT = {
		8'hC8, 8'hB4, 8'hA0, 8'h8C, 8'h82, 8'h78, 8'h64, 8'h50,
		8'h3C, 8'h32, 8'h28, 8'h1E, 8'h14, 8'h0C, 8'h06, 8'h00};

	// Sticky event flags
	typedef struct packed {
		logic undervoltage_lockout_flag;
		logic low_voltage_flag;
		logic low_charge_flag;
		logic battery_removed_flag;
	} flags_t;

	// Whole block state
	typedef struct packed {
		logic [4:0]                      mode;
		logic                            alarm_drive;
		logic                            power_on_detect;
		flags_t                          flags;
		logic                            force_counting_state;
		logic                            force_voltage_state;
		logic                            conversion_counter_clear;
		logic                            soft_reset;
		logic [7:0]                      rdata;
		logic [TAB_POINTS-1:0][15:0]     lookup_ocv_point;
		logic [TAB_POINTS-1:0][7:0]      lookup_soc_point;
		logic                            alarm_s1;
		logic                            alarm_s2;
		logic                            detect_s1;
		logic                            detect_s2;
	} state_t;

endpackage : gauge_regs_pkg

// *** rtl/gauge_mode_control_regs.sv ***
// Mode and control/status registers of the gauge, with the lookup table.
// Assumes the serial front end presents one-cycle read/write strobes on mclk;
// pins alarm and battery detect arrive asynchronously.
//
// Notes on behaviour
// - Mode bit0: mixed or voltage-only, default 1
// - Mode bit1: detect pin pull-up, default 1
// - Mode bit2: force charge-disable high, default 0
// - Mode bit4 low holds standby, default 0
// - Mode bit5: force counting state, counter zero
// - Mode bit6: force voltage state, counter max
// - Ctrl bit0 read gives alarm pin level
// - Ctrl bit0 write 0 forces alarm low
// - Ctrl bit1 write 1 clears conversion counter
// - Ctrl bit2 reads SOC source, voltage=1
// - Ctrl bit3 removal flag, clear only detect low
// - Ctrl bit4 reads power-on detect, default 1
// - Ctrl bit4 write: soft reset, sets/clears detect
// - Ctrl bit5 low-charge flag, cleared by 0
// - Ctrl bit6/7 low-voltage, lockout flags, write-0 clear
// - Reset loads sixteen-point default lookup table
// - Point: two-byte OCV, one-byte SOC
// - Reset restores defaults, power-on detect set
`timescale 1ns/100ps
module gauge_mode_control_regs
	import gauge_regs_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [6:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       alarm_pin_in,
	output logic            alarm_pin_out,
	output logic            alarm_pin_oe,
	input  wire logic       battery_detect_in,
	input  wire logic       alarm_condition_in,
	input  wire logic       swap_charge_disable_in,
	input  wire logic       soc_from_voltage,
	input  wire logic       low_charge_event,
	input  wire logic       low_voltage_event,
	input  wire logic       undervoltage_event,
	output logic            voltage_only_select,
	output logic            removal_pin_pullup_en,
	output logic            charge_disable_out,
	output logic            alarm_function_en,
	output logic            gauge_run,
	output logic            force_counting_state,
	output logic            force_voltage_state,
	output logic            conversion_counter_clear,
	output logic            soft_reset,
	output logic [TAB_POINTS*16-1:0] lookup_ocv_table,
	output logic [TAB_POINTS*8-1:0]  lookup_soc_table
);

	// Constant image of every register after reset
	localparam state_t STATE_RESET = '{
		mode:             MODE_RESET,
		alarm_drive:      ALARM_DRIVE_RESET,
		power_on_detect:  POR_DET_RESET,
		lookup_ocv_point: OCV_DEFAULT,
		lookup_soc_point: SOC_DEFAULT,
		default:          '0
	};

	state_t st;
	state_t next_st;

	// Table address decode, shared by read and write paths
	function automatic logic in_ocv(input logic [6:0] a);
		in_ocv = (a >= OCV_TAB_BASE) && (a < SOC_TAB_BASE);
	endfunction : in_ocv

	function automatic logic in_soc(input logic [6:0] a);
		in_soc = (a >= SOC_TAB_BASE) && (a < TAB_END);
	endfunction : in_soc

	// Next-state logic for registers, flags and synchronisers
	always_comb begin
		logic [6:0] ocv_off;
		logic [6:0] soc_off;
		logic [3:0] idx;
		ocv_off = reg_addr - OCV_TAB_BASE;
		soc_off = reg_addr - SOC_TAB_BASE;
		idx     = '0;
		next_st = st;
		// Two flops before any logic sees a pin
		next_st.alarm_s1  = alarm_pin_in;
		next_st.alarm_s2  = st.alarm_s1;
		next_st.detect_s1 = battery_detect_in;
		next_st.detect_s2 = st.detect_s1;
		// Command pulses last one cycle only
		next_st.force_counting_state     = 1'b0;
		next_st.force_voltage_state      = 1'b0;
		next_st.conversion_counter_clear = 1'b0;
		next_st.soft_reset               = 1'b0;

		// Read path, registered answer
		if (reg_rd) begin
			if (reg_addr == MODE_ADDR) begin
				next_st.rdata = {3'b000, st.mode};
			end else if (reg_addr == CTRL_ADDR) begin
				next_st.rdata[CTRL_ALARM_PIN] = st.alarm_s2;
				next_st.rdata[CTRL_CNT_CLEAR] = 1'b0;
				next_st.rdata[CTRL_SOC_VOLT]  = soc_from_voltage;
				next_st.rdata[CTRL_REMOVED]   = st.flags.battery_removed_flag;
				next_st.rdata[CTRL_POR]       = st.power_on_detect;
				next_st.rdata[CTRL_LOW_SOC]   = st.flags.low_charge_flag;
				next_st.rdata[CTRL_LOW_VOLT]  = st.flags.low_voltage_flag;
				next_st.rdata[CTRL_UVLO]      = st.flags.undervoltage_lockout_flag;
			end else if (in_ocv(reg_addr)) begin
				idx = ocv_off[4:1];
				next_st.rdata = ocv_off[0] ? st.lookup_ocv_point[idx][15:8]
					: st.lookup_ocv_point[idx][7:0];
			end else if (in_soc(reg_addr)) begin
				idx = soc_off[3:0];
				next_st.rdata = st.lookup_soc_point[idx];
			end else begin
				next_st.rdata = 8'h00; // Unmapped reads zero
			end
		end

		// Write path
		if (reg_wr) begin
			if (reg_addr == MODE_ADDR) begin
				next_st.mode = reg_wdata[4:0];
				next_st.force_counting_state = reg_wdata[MODE_FORCE_COUNTING_STATE];
				next_st.force_voltage_state  = reg_wdata[MODE_FORCE_VOLTAGE_STATE];
			end else if (reg_addr == CTRL_ADDR) begin
				next_st.alarm_drive = reg_wdata[CTRL_ALARM_PIN];
				next_st.conversion_counter_clear = reg_wdata[CTRL_CNT_CLEAR];
				next_st.power_on_detect = reg_wdata[CTRL_POR];
				// Write 0 clears; write 1 ignored
				if (!reg_wdata[CTRL_REMOVED] && !st.detect_s2) begin
					next_st.flags.battery_removed_flag = 1'b0;
				end
				if (!reg_wdata[CTRL_LOW_SOC]) begin
					next_st.flags.low_charge_flag = 1'b0;
				end
				if (!reg_wdata[CTRL_LOW_VOLT]) begin
					next_st.flags.low_voltage_flag = 1'b0;
				end
				if (!reg_wdata[CTRL_UVLO]) begin
					next_st.flags.undervoltage_lockout_flag = 1'b0;
				end
			end else if (in_ocv(reg_addr)) begin
				idx = ocv_off[4:1];
				if (ocv_off[0]) begin
					next_st.lookup_ocv_point[idx][15:8] = reg_wdata;
				end else begin
					next_st.lookup_ocv_point[idx][7:0] = reg_wdata;
				end
			end else if (in_soc(reg_addr)) begin
				idx = soc_off[3:0];
				next_st.lookup_soc_point[idx] = reg_wdata;
			end
		end

		// Events set after clears so a same-cycle event wins
		if (st.detect_s2) begin
			next_st.flags.battery_removed_flag = 1'b1;
		end
		// Monitoring halted in standby, so low-charge and low-voltage events are gated
		if (low_charge_event && st.mode[MODE_RUN]) begin
			next_st.flags.low_charge_flag = 1'b1;
		end
		if (low_voltage_event && st.mode[MODE_RUN]) begin
			next_st.flags.low_voltage_flag = 1'b1;
		end
		if (undervoltage_event) begin
			next_st.flags.undervoltage_lockout_flag = 1'b1;
		end

		// Soft reset restores defaults but keeps the pin synchronisers
		if (reg_wr && reg_addr == CTRL_ADDR && reg_wdata[CTRL_POR]) begin
			next_st = STATE_RESET;
			next_st.power_on_detect = 1'b1;
			next_st.soft_reset = 1'b1;
			next_st.alarm_s1  = alarm_pin_in;
			next_st.alarm_s2  = st.alarm_s1;
			next_st.detect_s1 = battery_detect_in;
			next_st.detect_s2 = st.detect_s1;
		end
	end

	// State register; defaults include the lookup table
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Mode outputs straight from flops, except charge disable, ORed with the swap input
	assign voltage_only_select   = st.mode[MODE_VOLT_ONLY];
	assign removal_pin_pullup_en = st.mode[MODE_PULLUP];
	assign alarm_function_en     = st.mode[MODE_ALARM_EN];
	assign gauge_run             = st.mode[MODE_RUN];
	assign charge_disable_out    = st.mode[MODE_CD_FORCE] | swap_charge_disable_in;

	// Command pulses
	assign force_counting_state     = st.force_counting_state;
	assign force_voltage_state      = st.force_voltage_state;
	assign conversion_counter_clear = st.conversion_counter_clear;
	assign soft_reset               = st.soft_reset;

	// Open-drain alarm: only ever pulls low
	assign alarm_pin_out = 1'b0;
	assign alarm_pin_oe  = ~st.alarm_drive | (st.mode[MODE_ALARM_EN] & alarm_condition_in);

	assign reg_rdata = st.rdata;

	// Table points flattened onto the outputs, one slice per point
	for (genvar p = 0; p < TAB_POINTS; p++) begin : g_points
		assign lookup_ocv_table[16*p +: 16] = st.lookup_ocv_point[p];
		assign lookup_soc_table[8*p +: 8]   = st.lookup_soc_point[p];
	end

	// Index is four bits wide and each window must hold every point exactly
	if (TAB_POINTS > 16
		|| (SOC_TAB_BASE - OCV_TAB_BASE) != 7'(2 * TAB_POINTS)
		|| (TAB_END - SOC_TAB_BASE) != 7'(TAB_POINTS)) begin : g_bad_map
		$error("lookup table map does not match point count");
	end

endmodule : gauge_mode_control_regs

// *** tb/gauge_mode_control_regs_props.sv ***
// Port checks on the gauge register block.
// Assumes one mclk domain with asynchronous active-low rstn.
`timescale 1ns/100ps
module gauge_mode_control_regs_props
	import gauge_regs_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic [6:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       alarm_pin_oe,
	input wire logic       swap_charge_disable_in,
	input wire logic       charge_disable_out,
	input wire logic       voltage_only_select,
	input wire logic       removal_pin_pullup_en,
	input wire logic       gauge_run,
	input wire logic       force_counting_state,
	input wire logic       force_voltage_state,
	input wire logic       conversion_counter_clear,
	input wire logic       soft_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Decoded writes to the two registers
	wire mw = reg_wr && reg_addr == MODE_ADDR;
	wire cw = reg_wr && reg_addr == CTRL_ADDR;
	a_count_pulse: assert property (force_counting_state == $past(mw && reg_wdata[5]))
		else $error("force counting pulse wrong");
	a_volt_pulse: assert property (force_voltage_state == $past(mw && reg_wdata[6]))
		else $error("force voltage pulse wrong");
	a_clear_pulse: assert property (cw && reg_wdata[1] |=> conversion_counter_clear)
		else $error("counter clear missing");
	a_soft_reset: assert property (cw && reg_wdata[4] |=> soft_reset && !gauge_run)
		else $error("soft reset missing");
	a_run_bit: assert property (mw |=> gauge_run == $past(reg_wdata[4]))
		else $error("run bit wrong");
	a_volt_mode: assert property (mw |=> voltage_only_select == $past(reg_wdata[0]))
		else $error("voltage-only bit wrong");
	a_pullup_bit: assert property (mw |=> removal_pin_pullup_en == $past(reg_wdata[1]))
		else $error("pull-up bit wrong");
	a_cd_out: assert property (
		mw |=> charge_disable_out == ($past(reg_wdata[2]) | swap_charge_disable_in))
		else $error("charge disable wrong");
	a_alarm_low: assert property (cw && !reg_wdata[0] && !reg_wdata[4] |=> alarm_pin_oe)
		else $error("alarm not forced low");
endmodule : gauge_mode_control_regs_props
bind gauge_mode_control_regs gauge_mode_control_regs_props u_gauge_mode_control_regs_props (
	.mclk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .alarm_pin_oe, .swap_charge_disable_in,
	.charge_disable_out, .voltage_only_select, .removal_pin_pullup_en, .gauge_run,
	.force_counting_state,
	.force_voltage_state, .conversion_counter_clear, .soft_reset);

// *** tb/gauge_host_model.sv ***
// Host stand-in: byte reads and writes on the register port.
// Assumes the port takes a strobe on the rising mclk edge.
`timescale 1ns/100ps
module gauge_host_model (
	output logic      [6:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic       mclk
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	// Strobe held across its taking edge; idle lines scrambled so stale data never helps
	task automatic xfer(input logic [6:0] a, input logic [7:0] d, input logic w);
		@(posedge mclk);
		#1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
		@(posedge mclk);
		#1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
	endtask : xfer
endmodule : gauge_host_model

// *** tb/gauge_mode_control_regs_bench.sv ***
// Self-checking bench for the gauge mode/control registers.
// Assumes the host model owns the byte port; pins and events are driven here.
`timescale 1ns/100ps
module gauge_mode_control_regs_bench;
	import gauge_regs_pkg::*;
	logic         mclk = 1'b0;
	logic         rstn, oe, det, cond, swap, sv, lc, lv, uv, cdo, run, vsel, reg_wr, reg_rd;
	logic         pu, aen;
	logic         rd_q = 1'b0;
	logic [6:0]   reg_addr;
	logic [7:0]   reg_wdata, reg_rdata, d, exp_q[$];
	logic [255:0] ocv;
	logic [127:0] soc;
	logic [31:0]  seed = 32'h0001488D;
	int           n_fail = 0, samples_checked = 0;
	gauge_host_model u_gauge_host_model (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
	// Alarm wire has a pull-up; the block only pulls it low
	gauge_mode_control_regs u_gauge_mode_control_regs (.mclk, .rstn, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .alarm_pin_in(!oe), .alarm_pin_out(), .alarm_pin_oe(oe),
		.battery_detect_in(det), .alarm_condition_in(cond), .swap_charge_disable_in(swap),
		.soc_from_voltage(sv), .low_charge_event(lc), .low_voltage_event(lv),
		.undervoltage_event(uv), .voltage_only_select(vsel), .removal_pin_pullup_en(pu),
		.charge_disable_out(cdo), .alarm_function_en(aen), .gauge_run(run), .force_counting_state(),
		.force_voltage_state(), .conversion_counter_clear(), .soft_reset(),
		.lookup_ocv_table(ocv), .lookup_soc_table(soc));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic cmp(input logic [39:0] e, input logic [39:0] a);
		samples_checked++;
		if (e !== a) $display("ERROR at %0t: expected %h got %h", $time, e, a);
		n_fail += int'(e !== a);
	endtask : cmp
	// Reads note their expected byte first; the watcher pairs it later
	task automatic io(input logic w, input logic [6:0] a, input logic [7:0] v);
		if (!w) exp_q.push_back(v);
		u_gauge_host_model.xfer(a, v, w);
	endtask : io
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	initial forever #5 mclk = ~mclk;
	// Read data is valid one cycle after the taken strobe
	always @(posedge mclk) begin
		if (rd_q) cmp(40'(exp_q.pop_front()), 40'(reg_rdata));
		rd_q <= reg_rd;
	end
	initial begin
		#20000 n_fail++;
		end_of_test();
	end
	initial begin
		{det, cond, swap, lc, lv, uv, rstn} = '0;
		sv = 1'(rnd());
		repeat (12) @(posedge mclk);
		#1 rstn = 1'b1;
		io(1'b0, MODE_ADDR, 8'h0B);
		io(1'b0, CTRL_ADDR, {5'h02, sv, 2'h1});
		// Both bytes of a point go out back to back
		for (int i = 0; i < TAB_POINTS; i++) begin
			io(1'b0, OCV_TAB_BASE + 7'(2 * i), OCV_DEFAULT[i][7:0]);
			io(1'b0, OCV_TAB_BASE + 7'(2 * i + 1), OCV_DEFAULT[i][15:8]);
			io(1'b0, SOC_TAB_BASE + 7'(i), SOC_DEFAULT[i]);
		end
		cmp(40'h17701DA9C8, {ocv[15:0], ocv[255:240], soc[127:120]});
		// Random mode values, command bits always set
		repeat (6) begin
			d = 8'(rnd()) | 8'h60;
			swap = d[7];
			io(1'b1, MODE_ADDR, d);
			cmp({d[2] | swap, d[4], d[3], d[1], d[0]}, {cdo, run, aen, pu, vsel});
			io(1'b0, MODE_ADDR, {3'h0, d[4:0]});
		end
		// Events while running; writing ones must not clear anything
		io(1'b1, MODE_ADDR, 8'h19);
		#1 {lc, lv, uv, det} = 4'hF;
		repeat (3) @(posedge mclk);
		#1 {lc, lv, uv} = 3'h0;
		io(1'b1, CTRL_ADDR, 8'hE9);
		io(1'b0, CTRL_ADDR, {5'h1D, sv, 2'h1});
		io(1'b1, CTRL_ADDR, 8'h01);
		io(1'b0, CTRL_ADDR, {5'h01, sv, 2'h1});
		#1 det = 1'b0;
		repeat (2) @(posedge mclk);
		io(1'b1, CTRL_ADDR, 8'h00);
		repeat (3) @(posedge mclk);
		io(1'b0, CTRL_ADDR, {5'h00, sv, 2'h0});
		io(1'b1, MODE_ADDR, 8'h1F);
		io(1'b1, CTRL_ADDR, 8'h10);
		repeat (3) @(posedge mclk);
		io(1'b0, MODE_ADDR, 8'h0B);
		io(1'b0, CTRL_ADDR, {5'h02, sv, 2'h1});
		io(1'b1, CTRL_ADDR, 8'h03);
		io(1'b0, CTRL_ADDR, {5'h00, sv, 2'h1});
		io(1'b0, 7'h20, 8'h00);
		repeat (2) @(posedge mclk);
		end_of_test();
	end
endmodule : gauge_mode_control_regs_bench
